// file: verilog/power_mode_wake_control.sv
`timescale 1ns/1ps
module power_mode_wake_control
    import power_mode_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic core_reset_n_i,
    input  wire logic simd_reset_n_i,
    input  wire logic debug_reset_n_i,
    input  wire logic wfi_exec_i,
    input  wire logic wfe_exec_i,
    input  wire logic mem_busy_i,
    input  wire logic irq_i,
    input  wire logic irq_unmasked_i,
    input  wire logic async_abort_i,
    input  wire logic async_abort_mask_i,
    input  wire logic ext_debug_request_i,
    input  wire logic debug_halt_cmd_i,
    input  wire logic exc_return_i,
    input  wire logic event_wake_in_i,
    input  wire logic simd_enable_i,
    input  wire logic simd_insn_i,
    input  wire logic fp_insn_i,
    input  wire logic debug_active_i,
    output logic      core_clk_en_o,
    output logic      wake_clk_en_o,
    output logic      debug_clk_en_o,
    output logic      simd_clk_en_o,
    output logic      fp_clk_en_o,
    output logic      ready_for_powerdown_o,
    output logic      wait_interrupt_state_o,
    output logic      wait_event_state_o,
    output logic      wake_o
);
    // pins are asynchronous to clk_i; everything else is core-clocked logic
    logic [5:0] pin_sync;

    sync_bank #(.W(6)) u_sync
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({~core_reset_n_i, ~simd_reset_n_i, ~debug_reset_n_i, // inverted so cleared stages read idle
                 ext_debug_request_i, event_wake_in_i, irq_i}),
        .q_o   (pin_sync)
    );
    logic core_rst_s;
    logic simd_rst_s;
    logic dbg_rst_s;
    logic dbg_req_s;
    logic evt_s;
    logic irq_s;
    assign core_rst_s = pin_sync[5];
    assign simd_rst_s = pin_sync[4];
    assign dbg_rst_s  = pin_sync[3];
    assign dbg_req_s  = pin_sync[2];
    assign evt_s      = pin_sync[1];
    assign irq_s      = pin_sync[0];
    logic dbg_req;
    assign dbg_req = dbg_req_s | debug_halt_cmd_i;
    function automatic logic wfi_wake(input logic irq, input logic abt, input logic dbg);
        // abort wakes regardless of its mask; masked irq wakes too
        wfi_wake = irq | abt | dbg;
    endfunction
    function automatic logic wfe_wake(input logic irqu, input logic dbg, input logic er,
                                      input logic ev);
        wfe_wake = irqu | dbg | er | ev;
    endfunction
    // exception return is remembered so a later wait for event falls through
    logic      evt_reg_ff;
    logic      nxt_evt_reg;
    pm_state_t state_ff;
    pm_state_t nxt_state;
    logic      tgt_wfe_ff;
    logic      nxt_tgt_wfe;
    logic      wake_ff;
    logic      nxt_wake;
    logic      rdy_ff;
    logic      nxt_rdy;
    logic      wfi_st_ff;
    logic      nxt_wfi_st;
    logic      wfe_st_ff;
    logic      nxt_wfe_st;
    logic ev_now;
    logic wi_wake;
    logic we_wake;
    assign ev_now  = evt_reg_ff | exc_return_i;
    assign wi_wake = wfi_wake(irq_s, async_abort_i, dbg_req) | core_rst_s;
    assign we_wake = wfe_wake(irq_s & irq_unmasked_i, dbg_req, ev_now, evt_s) | core_rst_s;

    always_comb
    begin
        nxt_state   = state_ff;
        nxt_tgt_wfe = tgt_wfe_ff;
        nxt_wake    = 1'b0;
        nxt_evt_reg = evt_reg_ff | exc_return_i;
        case (state_ff)
            ST_RUN:
            begin
                if (wfi_exec_i)
                begin
                    if (wi_wake)
                        nxt_wake = 1'b1;
                    else
                    begin
                        nxt_state   = ST_WAIT;
                        nxt_tgt_wfe = 1'b0;
                    end
                end
                else if (wfe_exec_i)
                begin
                    if (we_wake)
                    begin
                        nxt_wake    = 1'b1;
                        nxt_evt_reg = exc_return_i; // set wins: a return in the clearing cycle stays pending
                    end
                    else
                    begin
                        nxt_state   = ST_WAIT;
                        nxt_tgt_wfe = 1'b1;
                    end
                end
            end
            ST_WAIT:
            begin
                if (tgt_wfe_ff ? we_wake : wi_wake)
                begin
                    nxt_state   = ST_RUN;
                    nxt_wake    = 1'b1;
                    nxt_evt_reg = exc_return_i;
                end
                else if (!mem_busy_i)
                    nxt_state = tgt_wfe_ff ? ST_SLPE : ST_SLPI;
            end
            ST_SLPI:
            begin
                if (wi_wake)
                begin
                    nxt_state = ST_RUN;
                    nxt_wake  = 1'b1;
                end
            end
            ST_SLPE:
            begin
                if (we_wake)
                begin
                    nxt_state   = ST_RUN;
                    nxt_wake    = 1'b1;
                    nxt_evt_reg = exc_return_i;
                end
            end
            default:
                nxt_state = ST_RUN;
        endcase
        nxt_rdy = (nxt_state == ST_SLPI);
        nxt_wfi_st = (nxt_state == ST_SLPI);
        nxt_wfe_st = (nxt_state == ST_SLPE);
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_ff   <= ST_RUN;
            tgt_wfe_ff <= 1'b0;
            wake_ff    <= 1'b0;
            evt_reg_ff <= 1'b0;
            rdy_ff     <= 1'b0;
            wfi_st_ff  <= 1'b0;
            wfe_st_ff  <= 1'b0;
        end
        else
        begin
            state_ff   <= nxt_state;
            tgt_wfe_ff <= nxt_tgt_wfe;
            wake_ff    <= nxt_wake;
            evt_reg_ff <= nxt_evt_reg;
            rdy_ff     <= nxt_rdy;
            wfi_st_ff  <= nxt_wfi_st;
            wfe_st_ff  <= nxt_wfe_st;
        end
    end
    // clock enables; registered so outputs come from flops
    logic core_en_ff;
    logic dbg_en_ff;
    logic simd_en_ff;
    logic fp_en_ff;
    logic nxt_core_en;
    logic nxt_dbg_en;
    logic nxt_simd_en;
    logic nxt_fp_en;
    logic wake_en_ff;
    logic nxt_wake_en;
    logic sleeping;
    assign sleeping = (nxt_state == ST_SLPI) || (nxt_state == ST_SLPE);

    always_comb
    begin
        nxt_core_en = ~sleeping;
        // debug logic keeps its clock in wait for interrupt, or in any wait while debug is active, unless held in reset
        nxt_dbg_en  = (~sleeping | debug_active_i | (nxt_state == ST_SLPI)) & ~dbg_rst_s;
        // simd engine gated off when disabled, idle or held in reset
        nxt_simd_en = ~sleeping & simd_enable_i & simd_insn_i & ~simd_rst_s;
        // scalar fp rides the core clock, independent of the simd engine
        nxt_fp_en   = ~sleeping & fp_insn_i;
        nxt_wake_en = 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            core_en_ff <= 1'b1;
            dbg_en_ff  <= 1'b1;
            simd_en_ff <= 1'b0;
            fp_en_ff   <= 1'b0;
            wake_en_ff <= 1'b1;
        end
        else
        begin
            core_en_ff <= nxt_core_en;
            dbg_en_ff  <= nxt_dbg_en;
            simd_en_ff <= nxt_simd_en;
            fp_en_ff   <= nxt_fp_en;
            wake_en_ff <= nxt_wake_en;
        end
    end

    assign core_clk_en_o          = core_en_ff;
    assign wake_clk_en_o          = wake_en_ff; // wake logic is never gated
    assign debug_clk_en_o         = dbg_en_ff;
    assign simd_clk_en_o          = simd_en_ff;
    assign fp_clk_en_o            = fp_en_ff;
    assign ready_for_powerdown_o  = rdy_ff;
    assign wait_interrupt_state_o = wfi_st_ff;
    assign wait_event_state_o     = wfe_st_ff;
    assign wake_o                 = wake_ff;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence wfi_in_s;
        state_ff == ST_SLPI;
    endsequence

    sequence wake_seen_s;
        wi_wake;
    endsequence

    wfi_exit_a: assert property (wfi_in_s ##0 wake_seen_s |=> state_ff == ST_RUN && wake_ff)
        else $error("interrupt wait not left on wake");
    wfe_exit_a: assert property (state_ff == ST_SLPE && we_wake |=> state_ff == ST_RUN)
        else $error("event wait not left on wake");
    pend_block_a: assert property (state_ff == ST_RUN && wfi_exec_i && wi_wake |=> state_ff == ST_RUN)
        else $error("entered wait with wake pending");
    entry_cause_a: assert property (state_ff == ST_RUN && !wfi_exec_i && !wfe_exec_i |=> state_ff == ST_RUN)
        else $error("wait entered without instruction");
    mem_drain_a: assert property (state_ff == ST_WAIT && mem_busy_i && !wi_wake && !we_wake
                                  |=> state_ff == ST_WAIT)
        else $error("slept with memory busy");
    clk_gate_a: assert property (state_ff == ST_SLPI || state_ff == ST_SLPE |-> !core_clk_en_o)
        else $error("core clock running in wait");
    dbg_live_a: assert property (state_ff == ST_SLPI && !dbg_rst_s |=> debug_clk_en_o)
        else $error("debug clock stopped in wait");
    rdy_set_a: assert property (state_ff == ST_WAIT && !tgt_wfe_ff && !mem_busy_i && !wi_wake
                                |=> ready_for_powerdown_o)
        else $error("ready not raised");
    rdy_drop_a: assert property (state_ff == ST_SLPI && wi_wake |=> !ready_for_powerdown_o)
        else $error("ready not dropped on wake");
    dbg_any_a: assert property (state_ff == ST_SLPI && debug_halt_cmd_i |=> state_ff == ST_RUN)
        else $error("halt command did not wake");
    abort_wake_a: assert property (wfi_in_s ##0 (async_abort_i && async_abort_mask_i) |=> state_ff == ST_RUN)
        else $error("masked abort did not wake");
endmodule

// file: shared/power_mode_pkg.sv
package power_mode_pkg;
    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_WAIT = 2'b01,
        ST_SLPI = 2'b11,
        ST_SLPE = 2'b10
    } pm_state_t;
    localparam logic [3:0] DRAIN_MAX      = 4'hF;
    localparam logic [3:0] DRAIN_COUNT_RST = 4'h0;
    localparam logic [1:0] PEND_DEPTH     = 2'h2;
endpackage

// file: verilog/sync_bank.sv
`timescale 1ns/1ps
module sync_bank
#(
    parameter int W = 8
)
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_q;

    // first stage feeds only the second stage
    always_comb
    begin
        nxt_meta = d_i;
        nxt_q    = meta_ff;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_ff <= '0;
            q_ff    <= '0;
        end
        else
        begin
            meta_ff <= nxt_meta;
            q_ff    <= nxt_q;
        end
    end

    assign q_o = q_ff;
endmodule

// file: tb/power_ctrl_model.sv
`timescale 1ns/1ps
module power_ctrl_model
(
    input  wire logic clk_i,
    input  wire logic ready_i,
    input  wire logic no_pd_i,
    input  wire logic pd_req_i,
    input  wire logic wake_req_i,
    output logic      core_reset_n_o,
    output logic      simd_reset_n_o,
    output logic      clamp_o,
    output logic      power_on_o
);
    initial
    begin
        core_reset_n_o = 1'b1;
        simd_reset_n_o = 1'b1;
        clamp_o = 1'b0;
        power_on_o = 1'b1;
    end
    // the controller alone sequences power-down and power-up
    always @(posedge clk_i)
    begin
        if (pd_req_i && ready_i && !no_pd_i && power_on_o)
        begin
            core_reset_n_o <= 1'b0;
            simd_reset_n_o <= 1'b0;
            repeat (2) @(posedge clk_i);
            clamp_o <= 1'b1;
            @(posedge clk_i);
            power_on_o <= 1'b0;
        end
        else if (wake_req_i && !power_on_o)
        begin
            power_on_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            clamp_o <= 1'b0;
            @(posedge clk_i);
            core_reset_n_o <= 1'b1;
            simd_reset_n_o <= 1'b1;
        end
    end
endmodule

// file: tb/power_mode_wake_control_tb.sv
`timescale 1ns/1ps
module power_mode_wake_control_tb;
    logic clk_i = 1'b0, rst_i = 1'b1, wfi_exec_i = 1'b0, wfe_exec_i = 1'b0, mem_busy_i = 1'b0;
    logic irq_i = 1'b0, irq_unmasked_i = 1'b0, async_abort_i = 1'b0, async_abort_mask_i = 1'b1;
    logic ext_debug_request_i = 1'b0, debug_halt_cmd_i = 1'b0, exc_return_i = 1'b0;
    logic event_wake_in_i = 1'b0, simd_enable_i = 1'b0, simd_insn_i = 1'b0, fp_insn_i = 1'b0;
    logic debug_active_i = 1'b0, debug_reset_n_i = 1'b1, pd_req = 1'b0, wake_req = 1'b0, debug_no_powerdown = 1'b0;
    logic core_reset_n_i, simd_reset_n_i, clamp, power_on;
    logic core_clk_en_o, wake_clk_en_o, debug_clk_en_o, simd_clk_en_o, fp_clk_en_o;
    logic ready_for_powerdown_o, wait_interrupt_state_o, wait_event_state_o, wake_o;
    int   err_total = 0;
    int   cmp_count = 0;
    power_mode_wake_control dut (.clk_i, .rst_i, .core_reset_n_i, .simd_reset_n_i, .debug_reset_n_i,
        .wfi_exec_i, .wfe_exec_i, .mem_busy_i, .irq_i, .irq_unmasked_i, .async_abort_i,
        .async_abort_mask_i, .ext_debug_request_i, .debug_halt_cmd_i, .exc_return_i,
        .event_wake_in_i, .simd_enable_i, .simd_insn_i, .fp_insn_i, .debug_active_i,
        .core_clk_en_o, .wake_clk_en_o, .debug_clk_en_o, .simd_clk_en_o, .fp_clk_en_o,
        .ready_for_powerdown_o, .wait_interrupt_state_o, .wait_event_state_o, .wake_o);
    power_ctrl_model ctrl (.clk_i, .ready_i(ready_for_powerdown_o), .no_pd_i(debug_no_powerdown),
        .pd_req_i(pd_req), .wake_req_i(wake_req), .core_reset_n_o(core_reset_n_i),
        .simd_reset_n_o(simd_reset_n_i), .clamp_o(clamp), .power_on_o(power_on));
    initial
    begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic chk(input string n, input logic s, input logic e);
        cmp_count++;
        if (s !== e)
        begin
            err_total++;
            $display("ERROR %s expected %b seen %b", n, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one wake source per code, 7 clears them all
    task automatic drive(input int src);
        @(posedge clk_i);
        irq_i <= (src == 0) || (src == 4);
        irq_unmasked_i <= (src == 4);
        async_abort_i <= (src == 1);
        ext_debug_request_i <= (src == 2);
        event_wake_in_i <= (src == 3);
    endtask
    task automatic exec(input logic wait_interrupt_state);
        @(posedge clk_i);
        wfi_exec_i <= wait_interrupt_state;
        wfe_exec_i <= !wait_interrupt_state;
        @(posedge clk_i);
        wfi_exec_i <= 1'b0;
        wfe_exec_i <= 1'b0;
        #1;
    endtask
    task automatic sleep(input logic wait_interrupt_state);
        int i;
        exec(wait_interrupt_state);
        for (i = 0; i < 20 && (wait_interrupt_state_o | wait_event_state_o) !== 1'b1; i++)
            @(posedge clk_i) #1;
    endtask
    task automatic halt_wake();
        @(posedge clk_i);
        debug_halt_cmd_i <= 1'b1;
        @(posedge clk_i);
        debug_halt_cmd_i <= 1'b0;
        #1;
        chk("state", wait_interrupt_state_o | wait_event_state_o, 1'b0);
        chk("ready", ready_for_powerdown_o, 1'b0);
        chk("wake", wake_o, 1'b1);
        chk("core_clk", core_clk_en_o, 1'b1);
    endtask
    task automatic t_wfi_basic();
        sleep(1'b1);
        chk("wfi_state", wait_interrupt_state_o, 1'b1);
        chk("wfe_state", wait_event_state_o, 1'b0);
        chk("ready", ready_for_powerdown_o, 1'b1);
        chk("core_clk", core_clk_en_o, 1'b0);
        chk("wake_clk", wake_clk_en_o, 1'b1);
        repeat (5) @(posedge clk_i);
        #1;
        chk("dbg_clk", debug_clk_en_o, 1'b1);
        chk("wfi_hold", wait_interrupt_state_o, 1'b1);
        halt_wake();
    endtask
    // a source that must not wake is left asleep, then cleared by a halt
    task automatic wake_try(input logic wait_interrupt_state, input int src, input logic exp);
        int i;
        sleep(wait_interrupt_state);
        chk("sleep_kind", wait_event_state_o, !wait_interrupt_state);
        chk("dbg_clk", debug_clk_en_o, wait_interrupt_state);
        drive(src);
        for (i = 0; i < 8 && (wait_interrupt_state_o | wait_event_state_o) === 1'b1; i++)
            @(posedge clk_i) #1;
        chk("woken", !(wait_interrupt_state_o | wait_event_state_o), exp);
        drive(7);
        if (!exp)
            halt_wake();
        repeat (4) @(posedge clk_i);
    endtask
    task automatic t_blocked(input logic wait_interrupt_state);
        int i;
        if (wait_interrupt_state)
            drive(0);
        else
        begin
            @(posedge clk_i);
            exc_return_i <= 1'b1;
            @(posedge clk_i);
            exc_return_i <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        exec(wait_interrupt_state);
        for (i = 0; i < 3 && wake_o !== 1'b1; i++)
            @(posedge clk_i) #1;
        chk("blk_wake", wake_o, 1'b1);
        chk("blk_state", wait_interrupt_state_o | wait_event_state_o, 1'b0);
        drive(7);
        repeat (4) @(posedge clk_i);
    endtask
    task automatic t_mem_busy();
        @(posedge clk_i);
        mem_busy_i <= 1'b1;
        exec(1'b1);
        repeat (6) @(posedge clk_i);
        #1;
        chk("busy_state", wait_interrupt_state_o, 1'b0);
        chk("busy_clk", core_clk_en_o, 1'b1);
        @(posedge clk_i);
        mem_busy_i <= 1'b0;
        sleep(1'b1);
        chk("late_state", wait_interrupt_state_o, 1'b1);
        halt_wake();
    endtask
    task automatic t_power();
        int i;
        sleep(1'b1);
        @(posedge clk_i);
        debug_no_powerdown <= 1'b1;
        pd_req <= 1'b1;
        repeat (6) @(posedge clk_i);
        #1;
        chk("emulate_pwr", power_on, 1'b1);
        chk("emulate_wfi", wait_interrupt_state_o, 1'b1);
        @(posedge clk_i);
        debug_no_powerdown <= 1'b0;
        for (i = 0; i < 20 && power_on !== 1'b0; i++)
            @(posedge clk_i) #1;
        chk("rst_before_off", core_reset_n_i, 1'b0);
        chk("rst_wakes", wait_interrupt_state_o, 1'b0);
        pd_req <= 1'b0;
        wake_req <= 1'b1;
        for (i = 0; i < 20 && core_reset_n_i !== 1'b1; i++)
            @(posedge clk_i) #1;
        chk("power_first", power_on, 1'b1);
        wake_req <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic t_simd();
        @(posedge clk_i);
        fp_insn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        chk("fp_clk", fp_clk_en_o, 1'b1);
        chk("simd_off", simd_clk_en_o, 1'b0);
        @(posedge clk_i);
        simd_enable_i <= 1'b1;
        simd_insn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        chk("simd_on", simd_clk_en_o, 1'b1);
        @(posedge clk_i);
        debug_reset_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        chk("dbg_rst_clk", debug_clk_en_o, 1'b0);
    endtask
    initial
    begin
        #200000;
        err_total++;
        give_verdict();
    end
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        t_wfi_basic();
        wake_try(1'b1, 0, 1'b1);
        wake_try(1'b1, 1, 1'b1);
        wake_try(1'b1, 2, 1'b1);
        wake_try(1'b1, 3, 1'b0);
        wake_try(1'b0, 0, 1'b0);
        wake_try(1'b0, 4, 1'b1);
        wake_try(1'b0, 2, 1'b1);
        wake_try(1'b0, 3, 1'b1);
        t_blocked(1'b1);
        t_blocked(1'b0);
        t_mem_busy();
        t_power();
        t_simd();
        give_verdict();
    end
endmodule
